// File: design/fcc_defs.svh
/*
 Constants for the fault capture control word: field positions, reset values, counts.
 Assumes inclusion by the package and the design modules; holds definitions only.
*/
`ifndef FCC_DEFS_SVH
`define FCC_DEFS_SVH
`define FCC_CMD_CODE      8'hf3
`define FCC_BIT_ARM       15
`define FCC_CNT_HI        11
`define FCC_CNT_LO        8
`define FCC_BIT_ONE_TIME  7
`define FCC_BIT_AFTER_EN  6
`define FCC_SEL_HI        4
`define FCC_SEL_LO        2
`define FCC_BIT_ERASE     1
`define FCC_BIT_ENABLE    0
`define FCC_SLOTS         4'h8
`define FCC_ZERO16        16'h0000
`define FCC_ERASE_MS      20
`define FCC_CLK_MHZ       100
`endif

// File: design/fcc_pkg.sv
/*
 Types shared by the fault capture control logic.
 Assumes fcc_defs.svh is on the include path.
*/
`include "fcc_defs.svh"
package fcc_pkg;
  typedef struct packed {
    logic       arm;
    logic       one_time;
    logic       after_en;
    logic [2:0] sel;
    logic       enable;
  } fcc_cfg_s;
  typedef enum logic [1:0] {FCC_IDLE, FCC_ERASE, FCC_STORE} fcc_state_e;
endpackage : fcc_pkg

// File: design/fcc_slot_counter.sv
/*
 Free record slot counter with erase restore and store decrement.
 Assumes erase and store never both asserted meaningfully; erase wins.
*/
`include "fcc_defs.svh"
module fcc_slot_counter
  import fcc_pkg::*;
#(
  parameter int SLOTS = 8
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       erase,
  input  wire logic       store,
  output logic [3:0]      free_q,
  output logic            empty_q
);
  // Count is four bits and the slot index three, so eight is the ceiling
  if (SLOTS < 1 || SLOTS > 8) begin : g_bad_slots
    $error("SLOTS out of range");
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      free_q <= 4'h0;
    end else if (erase) begin
      free_q <= 4'(SLOTS);
    end else if (store && free_q != 4'h0) begin
      free_q <= free_q - 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      empty_q <= 1'b1;
    end else if (erase) begin
      empty_q <= 1'b0;
    end else if (store && free_q == 4'h1) begin
      empty_q <= 1'b1;
    end
  end
endmodule : fcc_slot_counter

// File: design/fcc_control.sv
/*
 Fault capture control word behind the management command decoder.
 Assumes the command decoder presents whole 16-bit writes as one-cycle strobes,
 and that fault, output state and flash ready come synchronous to clk.
*/
`include "fcc_defs.svh"
module fcc_control
  import fcc_pkg::*;
#(
  parameter int SLOTS       = 8,
  parameter int ERASE_TICKS = `FCC_ERASE_MS * 1000 * `FCC_CLK_MHZ
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wr_stb,
  input  wire logic [15:0] wr_data,
  output logic [15:0]      rd_data_q,
  input  wire logic        fault,
  input  wire logic        out_enabled,
  input  wire logic        out_disable,
  input  wire logic        flash_done,
  output logic             snap_live_q,
  output logic             store_req_q,
  output logic [2:0]       store_slot_q,
  output logic             erase_req_q,
  output logic             erase_busy_q,
  output logic [2:0]       read_sel_q
);
  fcc_cfg_s   cfg_q;
  fcc_state_e st_q;
  logic [3:0] free_q;
  logic       empty_q;
  logic [31:0] tick_q;
  logic       took_one_q;
  logic       erase_go;
  logic       store_go;
  logic       capture_ok;

  // Elaboration checks: counter is four bits, slot index three bits
  if (SLOTS < 1 || SLOTS > 8) begin : g_bad_slots
    $error("SLOTS out of range");
  end
  if (ERASE_TICKS < 1) begin : g_bad_ticks
    $error("ERASE_TICKS must be positive");
  end

  // Readback image of the control word; count is live, erase bit never stored
  function automatic logic [15:0] fcc_pack_word(input fcc_cfg_s c, input logic [3:0] free);
    logic [15:0] w;
    w                          = `FCC_ZERO16;
    w[`FCC_BIT_ARM]            = c.arm;
    w[`FCC_CNT_HI:`FCC_CNT_LO] = free;
    w[`FCC_BIT_ONE_TIME]       = c.one_time;
    w[`FCC_BIT_AFTER_EN]       = c.after_en;
    w[`FCC_SEL_HI:`FCC_SEL_LO] = c.sel;
    w[`FCC_BIT_ENABLE]         = c.enable;
    return w;
  endfunction : fcc_pack_word

  // Erase only when the bit is set; other bits of that word are dropped
  assign erase_go = wr_stb && wr_data[`FCC_BIT_ERASE] && st_q == FCC_IDLE;
  // Gating: enabled, armed, slot left, output state and one-shot limits
  assign capture_ok = cfg_q.enable && cfg_q.arm && !empty_q
                    && (!cfg_q.after_en || out_enabled)
                    && (!cfg_q.one_time || !took_one_q);
  assign store_go = fault && capture_ok && st_q == FCC_IDLE && !wr_stb;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_q <= '0;
    end else if (wr_stb && !wr_data[`FCC_BIT_ERASE] && st_q == FCC_IDLE) begin
      cfg_q.arm      <= wr_data[`FCC_BIT_ARM];
      cfg_q.one_time <= wr_data[`FCC_BIT_ONE_TIME];
      cfg_q.after_en <= wr_data[`FCC_BIT_AFTER_EN];
      cfg_q.sel      <= wr_data[`FCC_SEL_HI:`FCC_SEL_LO];
      cfg_q.enable   <= wr_data[`FCC_BIT_ENABLE];
    end
  end

  // One-shot: records stop once a store has been taken with out_disable high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      took_one_q <= 1'b0;
    end else if (erase_go || (wr_stb && !cfg_q.one_time)) begin
      took_one_q <= 1'b0;
    end else if (store_go && cfg_q.one_time && out_disable) begin
      took_one_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q   <= FCC_IDLE;
      tick_q <= 32'h0;
    end else begin
      case (st_q)
        FCC_IDLE: begin
          if (erase_go) begin
            st_q   <= FCC_ERASE;
            tick_q <= 32'(ERASE_TICKS - 1);
          end else if (store_go) begin
            st_q <= FCC_STORE;
          end
        end
        FCC_ERASE: begin
          // Host stays off the bus meanwhile; writes here are dropped anyway
          if (tick_q == 32'h0) begin
            st_q <= FCC_IDLE;
          end else begin
            tick_q <= tick_q - 32'h1;
          end
        end
        FCC_STORE: begin
          if (flash_done) begin
            st_q <= FCC_IDLE;
          end
        end
        default: st_q <= FCC_IDLE;
      endcase
    end
  end

  fcc_slot_counter #(
    .SLOTS (SLOTS)
  ) u_slots (
    .clk     (clk),
    .nrst    (nrst),
    .erase   (erase_go),
    .store   (store_go),
    .free_q  (free_q),
    .empty_q (empty_q)
  );

  // Pulse and slot index to the flash store engine
  always_ff @(posedge clk) begin
    if (!nrst) begin
      store_req_q  <= 1'b0;
      store_slot_q <= 3'h0;
    end else begin
      store_req_q  <= store_go;
      // Index held between stores so a slow engine may latch it late
      store_slot_q <= store_go ? 3'(SLOTS - int'(free_q)) : store_slot_q;
    end
  end

  // Erase pulse and the quiet window that follows it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      erase_req_q  <= 1'b0;
      erase_busy_q <= 1'b0;
    end else begin
      erase_req_q  <= erase_go;
      erase_busy_q <= erase_go || (st_q == FCC_ERASE && tick_q != 32'h0);
    end
  end

  // Record select and live image gate, registered so outputs never glitch
  always_ff @(posedge clk) begin
    if (!nrst) begin
      read_sel_q  <= 3'h0;
      snap_live_q <= 1'b0;
    end else begin
      read_sel_q  <= cfg_q.sel;
      snap_live_q <= cfg_q.enable;
    end
  end

  // Readback: erase bit and unused bits always zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_data_q <= `FCC_ZERO16;
    end else begin
      rd_data_q <= fcc_pack_word(cfg_q, free_q);
    end
  end
endmodule : fcc_control

// File: test/fcc_control_checker.sv
/*
 Port assertions for the fault capture control word.
 Assumes one clock, sync active-low reset and ERASE_TICKS near 10.
*/
module fcc_control_checker
  import fcc_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        wr_stb,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] rd_data_q,
  input wire logic        fault,
  input wire logic        out_enabled,
  input wire logic        flash_done,
  input wire logic        snap_live_q,
  input wire logic        store_req_q,
  input wire logic [2:0]  store_slot_q,
  input wire logic        erase_req_q,
  input wire logic        erase_busy_q,
  input wire logic [2:0]  read_sel_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic st_q;
  wire  idle_w = !erase_busy_q && !st_q && !store_req_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Store in flight; writes then are dropped, so not judged
  always_ff @(posedge clk) begin
    if (!nrst) st_q <= 1'b0;
    else if (store_req_q) st_q <= 1'b1;
    else if (flash_done) st_q <= 1'b0;
  end
  AST_ERASE_REQ: assert property (wr_stb && wr_data[1] && idle_w |=> erase_req_q)
    else $error("erase write not taken");
  AST_ERASE_CNT: assert property (erase_req_q |=> rd_data_q[11:8] == 4'h8)
    else $error("count not eight after erase");
  AST_BUSY_SPAN: assert property (erase_req_q |-> erase_busy_q[*8] ##[1:4] !erase_busy_q)
    else $error("erase window length wrong");
  AST_RSV_ZERO: assert property (rd_data_q[14:12] == 3'h0 && !rd_data_q[5] && !rd_data_q[1])
    else $error("unused or erase bit reads one");
  AST_CFG: assert property (wr_stb && !wr_data[1] && idle_w |-> ##2
    {rd_data_q[15], rd_data_q[7:6], rd_data_q[4:0], read_sel_q, snap_live_q}
    == $past({wr_data[15], wr_data[7:6], wr_data[4:2], 1'b0, wr_data[0], wr_data[4:2], wr_data[0]}, 2))
    else $error("config fields wrong");
  AST_DEC: assert property (store_req_q |=> rd_data_q[11:8] == $past(rd_data_q[11:8]) - 4'h1)
    else $error("count not decremented");
  AST_STORE_OK: assert property (store_req_q |-> $past(fault) && rd_data_q[15] && rd_data_q[0]
    && rd_data_q[11:8] != 4'h0) else $error("store without cause");
  AST_GATE: assert property (store_req_q && rd_data_q[6] |-> $past(out_enabled))
    else $error("store while output off");
  AST_SLOT: assert property (store_req_q |-> store_slot_q == 3'(4'h8 - rd_data_q[11:8]))
    else $error("store slot index wrong");
  cover property (store_req_q && rd_data_q[7]);
  cover property (erase_req_q);
  cover property (store_req_q);
  cover property (wr_stb && !wr_data[1]);
endmodule : fcc_control_checker
bind fcc_control fcc_control_checker chk_i (.*);

// File: test/fcc_flash_model.sv
/*
 Flash store engine stand-in answering each store request.
 Assumes store requests are one-cycle pulses; lat sets its speed.
*/
module fcc_flash_model (
  input wire logic       clk,
  input wire logic [3:0] lat,
  input wire logic       store_req_q,
  output logic           flash_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q = 4'h0;
  initial flash_done = 1'b0;
  // Latest image lands in flash lat+1 cycles after the store request
  always @(posedge clk) begin
    flash_done <= (cnt_q == 4'h1);
    if (store_req_q) cnt_q <= lat;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
endmodule : fcc_flash_model

// File: test/tb_top.sv
/*
 Self-checking bench for the fault capture control word.
 Assumes ERASE_TICKS of 10, so a 14-cycle gap stands for 20 ms.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, nrst = 0, wr_stb = 0, fault = 0, out_enabled = 0, out_disable = 0;
  logic [15:0] wr_data = 16'h0000, rd_data_q;
  logic [3:0]  lat = 4'h2;
  logic        flash_done, snap_live_q, store_req_q, erase_req_q, erase_busy_q;
  logic [2:0]  store_slot_q, read_sel_q;
  int          error_cnt = 0, samples_checked = 0;
  always #5 clk = ~clk;
  fcc_control #(.ERASE_TICKS(10)) uut (.*);
  fcc_flash_model fm (.*);
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task wr(input logic [15:0] d);
    @(posedge clk);
    wr_stb  <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_stb  <= 1'b0;
  endtask : wr
  task flt(input logic en, input logic dis);
    @(posedge clk);
    out_enabled <= en;
    out_disable <= dis;
    fault       <= 1'b1;
    @(posedge clk);
    fault       <= 1'b0;
  endtask : flt
  // Gap also honours the quiet time after an erase
  task step(input string t, input logic [19:0] e);
    repeat (14) @(posedge clk);
    #1;
    samples_checked++;
    if ({read_sel_q, snap_live_q, rd_data_q} !== e) begin
      error_cnt++;
      $display("Error %s sel/live/word expected %h seen %h", t, e, {read_sel_q, snap_live_q, rd_data_q});
    end
    $display("%s done", t);
  endtask : step
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    step("reset", 20'h00000);
    wr(16'hffff);
    step("erase", 20'h00800);
    wr(16'hf065);
    step("config", 20'h38845);
    flt(1'b0, 1'b0);
    step("gated", 20'h38845);
    flt(1'b1, 1'b0);
    step("store", 20'h38745);
    lat <= 4'h6;
    wr(16'h8081);
    step("one time cfg", 20'h18781);
    flt(1'b1, 1'b1);
    step("one time a", 20'h18681);
    flt(1'b1, 1'b1);
    step("one time b", 20'h18681);
    wr(16'h8000);
    flt(1'b1, 1'b0);
    step("disabled", 20'h08600);
    wr(16'h0001);
    step("readback", 20'h10601);
    summarize;
  end
  initial begin
    repeat (1000) @(posedge clk);
    error_cnt++;
    summarize;
  end
endmodule : tb_top
